// File: debug_target_regs.vh
// Constants for the two-wire debug target-select block
`ifndef DEBUG_TARGET_REGS_VH
`define DEBUG_TARGET_REGS_VH

// ============================================================
// Target-select register
`define TSEL_WIDTH        8
`define TSEL_RESET        8'h00

// ============================================================
// Target-select values
`define TSEL_DEVICE_ID    8'h00
`define TSEL_REVISION_ID  8'h01
`define TSEL_FLASH_CTRL   8'h02
`define TSEL_FLASH_DATA   8'hb4

// ============================================================
// Frame layout on the link
`define LINK_START_LEVEL  1'b0
`define INS_WIDTH         2
`define INS_DATA_READ     2'h0
`define INS_DATA_WRITE    2'h1
`define INS_ADDR_READ     2'h2
`define INS_ADDR_WRITE    2'h3
`define DATA_BITS         4'h8

// ============================================================
// Answer to a data read of an unused target
`define UNMAPPED_READ     8'h00

`endif

// File: debug_link_sync.v
// Two-flip-flop synchroniser for the debug link pins
`timescale 1ns/1ps
`default_nettype none

module debug_link_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;

  // ============================================================
  // Two stages; first stage feeds only the second
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_o   <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// File: debug_target_select.v
// Two-wire debug link slave with target-select register
`timescale 1ns/1ps
`default_nettype none
`include "debug_target_regs.vh"

module debug_target_select #(
  parameter [7:0] DEVICE_ID   = 8'h5a, // Arbitrary value
  parameter [7:0] REVISION_ID = 8'h01  // Arbitrary value
) (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire       debug_link_clock_i,
  input  wire       debug_link_data_i,
  output reg        debug_link_data_o,
  output reg        debug_link_data_oe_o,
  output reg  [7:0] target_select_o,
  input  wire [7:0] flash_ctrl_rdata_i,
  input  wire [7:0] flash_data_rdata_i,
  output reg  [7:0] flash_wdata_o,
  output reg        flash_ctrl_wr_o,
  output reg        flash_data_wr_o,
  output reg        flash_ctrl_rd_o,
  output reg        flash_data_rd_o
);

  // ============================================================
  // Frame states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_INS  = 2'h1;
  localparam [1:0] ST_WDAT = 2'h2;
  localparam [1:0] ST_RDAT = 2'h3;

  wire [1:0] pins_sync;
  reg        clk_prev_reg;
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [1:0] ins_reg;
  reg  [1:0] ins_next;
  reg  [3:0] cnt_reg;
  reg  [3:0] cnt_next;
  reg  [7:0] shift_reg;
  reg  [7:0] shift_next;
  reg  [7:0] tsel_next;
  reg        data_next;
  reg        oe_next;
  reg  [7:0] wdata_next;
  reg        ctrl_wr_next;
  reg        data_wr_next;
  reg        ctrl_rd_next;
  reg        data_rd_next;
  reg  [7:0] read_value;

  // ============================================================
  // Link pins into the system clock domain
  debug_link_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({debug_link_clock_i, debug_link_data_i}),
    .sync_o    (pins_sync)
  );

  wire link_clk  = pins_sync[1];
  wire link_data = pins_sync[0];
  wire link_rise = link_clk & ~clk_prev_reg;
  wire link_fall = ~link_clk & clk_prev_reg;

  // ============================================================
  // Data register chosen by the select value
  always @* begin
    case (target_select_o)
      `TSEL_DEVICE_ID:   read_value = DEVICE_ID;
      `TSEL_REVISION_ID: read_value = REVISION_ID;
      `TSEL_FLASH_CTRL:  read_value = flash_ctrl_rdata_i;
      `TSEL_FLASH_DATA:  read_value = flash_data_rdata_i;
      default:           read_value = `UNMAPPED_READ;
    endcase
  end

  // ============================================================
  // Frame decoder: start, instruction, data in or data out
  always @* begin
    state_next   = state_reg;
    ins_next     = ins_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    tsel_next    = target_select_o;
    data_next    = debug_link_data_o;
    oe_next      = debug_link_data_oe_o;
    wdata_next   = flash_wdata_o;
    ctrl_wr_next = 1'b0;
    data_wr_next = 1'b0;
    ctrl_rd_next = 1'b0;
    data_rd_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        oe_next = 1'b0;
        if (link_rise && link_data == `LINK_START_LEVEL) begin
          state_next = ST_INS;
          cnt_next   = 4'h0;
        end
      end
      ST_INS: begin
        if (link_rise) begin
          ins_next = {link_data, ins_reg[1]}; // LSB first
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'h1) begin
            cnt_next = 4'h0;
            if (link_data) begin
              // Address instructions: bit 1 set
              if (ins_reg[1]) begin
                state_next = ST_WDAT;
              end else begin
                state_next = ST_RDAT;
                shift_next = target_select_o;
              end
            end else if (ins_reg[1]) begin
              state_next = ST_WDAT;
            end else begin
              // Data read latches the selected register now
              state_next   = ST_RDAT;
              shift_next   = read_value;
              ctrl_rd_next = (target_select_o == `TSEL_FLASH_CTRL);
              data_rd_next = (target_select_o == `TSEL_FLASH_DATA);
            end
          end
        end
      end
      ST_WDAT: begin
        if (link_rise) begin
          shift_next = {link_data, shift_reg[7:1]};
          cnt_next   = cnt_reg + 4'h1;
          if (cnt_reg == `DATA_BITS - 4'h1) begin
            state_next = ST_IDLE;
            if (ins_reg == `INS_ADDR_WRITE) begin
              tsel_next = {link_data, shift_reg[7:1]};
            end else begin
              wdata_next   = {link_data, shift_reg[7:1]};
              ctrl_wr_next = (target_select_o == `TSEL_FLASH_CTRL);
              data_wr_next = (target_select_o == `TSEL_FLASH_DATA);
            end
          end
        end
      end
      ST_RDAT: begin
        // Device drives after each of the first 8 falling edges, host samples on rise; the next fall releases
        if (link_fall) begin
          if (cnt_reg == `DATA_BITS) begin
            oe_next    = 1'b0;
            state_next = ST_IDLE;
          end else begin
            oe_next    = 1'b1;
            data_next  = shift_reg[0];
            shift_next = {1'b0, shift_reg[7:1]};
            cnt_next   = cnt_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        oe_next    = 1'b0;
      end
    endcase
  end

  // ============================================================
  // State and output registers
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      clk_prev_reg         <= 1'b1;
      state_reg            <= ST_IDLE;
      ins_reg              <= 2'h0;
      cnt_reg              <= 4'h0;
      shift_reg            <= 8'h00;
      target_select_o      <= `TSEL_RESET;
      debug_link_data_o    <= 1'b0;
      debug_link_data_oe_o <= 1'b0;
      flash_wdata_o        <= 8'h00;
      flash_ctrl_wr_o      <= 1'b0;
      flash_data_wr_o      <= 1'b0;
      flash_ctrl_rd_o      <= 1'b0;
      flash_data_rd_o      <= 1'b0;
    end else begin
      clk_prev_reg         <= link_clk;
      state_reg            <= state_next;
      ins_reg              <= ins_next;
      cnt_reg              <= cnt_next;
      shift_reg            <= shift_next;
      target_select_o      <= tsel_next;
      debug_link_data_o    <= data_next;
      debug_link_data_oe_o <= oe_next;
      flash_wdata_o        <= wdata_next;
      flash_ctrl_wr_o      <= ctrl_wr_next;
      flash_data_wr_o      <= data_wr_next;
      flash_ctrl_rd_o      <= ctrl_rd_next;
      flash_data_rd_o      <= data_rd_next;
    end
  end

endmodule

`default_nettype wire

// File: debug_target_select_asserts.sv
// Checker for the debug target-select block
`timescale 1ns/1ps
`default_nettype none
module debug_target_select_asserts (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       debug_link_clock_i,
  input wire logic       debug_link_data_o,
  input wire logic       debug_link_data_oe_o,
  input wire logic [7:0] target_select_o,
  input wire logic       flash_ctrl_wr_o,
  input wire logic       flash_data_wr_o,
  input wire logic       flash_ctrl_rd_o,
  input wire logic       flash_data_rd_o
);
  // ============================================================
  // Select register, strobes and line driving
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_rst; disable iff (1'b0)
    !rst_n_i |=> target_select_o == 8'h00 && !debug_link_data_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_ctl; (flash_ctrl_wr_o || flash_ctrl_rd_o) |-> target_select_o == 8'h02
    ##1 !flash_ctrl_wr_o; endproperty
  a_ctl: assert property (p_ctl) else $error("control strobe wrong");
  property p_dat; (flash_data_wr_o || flash_data_rd_o) |-> target_select_o == 8'hb4
    ##1 !flash_data_wr_o; endproperty
  a_dat: assert property (p_dat) else $error("data strobe wrong");
  property p_sel; $changed(target_select_o) |-> debug_link_clock_i; endproperty
  a_sel: assert property (p_sel) else $error("select moved mid bit");
  property p_oer; $rose(debug_link_data_oe_o) |-> !debug_link_clock_i; endproperty
  a_oer: assert property (p_oer) else $error("drive began on high clock");
  property p_oef; $fell(debug_link_data_oe_o) |-> !debug_link_clock_i; endproperty
  a_oef: assert property (p_oef) else $error("release on high clock");
  property p_bit; debug_link_data_oe_o && $changed(debug_link_data_o) |-> !debug_link_clock_i;
  endproperty
  a_bit: assert property (p_bit) else $error("bit moved on high clock");
  // Main scenarios reached
  c_cwr: cover property (flash_ctrl_wr_o);
  c_drd: cover property (flash_data_rd_o);
  c_oe: cover property ($rose(debug_link_data_oe_o));
endmodule
bind debug_target_select debug_target_select_asserts chk_u (.clk_sys_i, .rst_n_i,
  .debug_link_clock_i, .debug_link_data_o, .debug_link_data_oe_o, .target_select_o,
  .flash_ctrl_wr_o, .flash_data_wr_o, .flash_ctrl_rd_o, .flash_data_rd_o);
`default_nettype wire

// File: debug_host_model.sv
// Host adapter model driving the two-wire debug link
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
  input  wire logic clk_sys_i,
  input  wire logic dev_data_i,
  input  wire logic dev_oe_i,
  output var  logic link_clock_o,
  output wire logic line_o
);
  logic hd = 1'b1;
  logic hoe = 1'b1;
  logic last = 1'b0;
  // ============================================================
  // Line level: device, host, else inverse of the last driven level
  assign line_o = dev_oe_i ? dev_data_i : (hoe ? hd : ~last);
  // Only a driven line updates the remembered level
  always @(posedge clk_sys_i) begin
    if (dev_oe_i || hoe) last <= line_o;
  end
  initial link_clock_o = 1'b1;
  // One link period: bit set while low, line sampled at the rise
  task automatic cyc(input logic b, output logic s);
    link_clock_o = 1'b0;
    hd = b;
    #62.5 link_clock_o = 1'b1;
    s = line_o;
    #62.5;
  endtask
  // Whole frame: start, instruction, then 8 data bits in one direction
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic s;
    int i;
    cyc(1'b0, s);
    for (i = 0; i < 2; i++) cyc(ins[i], s);
    hoe = ins[0];
    for (i = 0; i < 8; i++) cyc(wd[i], rd[i]);
    if (!ins[0]) begin
      // Turnaround fall: retake the line high before the rise, no false start
      link_clock_o = 1'b0;
      #50 hd = 1'b1;
      hoe = 1'b1;
      #12.5 link_clock_o = 1'b1;
      #62.5;
    end
    hd = 1'b1;
    hoe = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the debug target-select block
`timescale 1ns/1ps
`default_nettype none
`include "debug_target_regs.vh"
module tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        lck, d_o, oe, cwr, dwr, crs, drs;
  wire logic   line;
  logic [7:0]  tsel, wdat, rb, wd, crd = 8'h00, drd = 8'h00, prev_tsel = 8'h00;
  logic [7:0]  sels [5] = '{8'h01, 8'h02, 8'hb4, 8'h00, 8'h37};
  logic [11:0] exp_q [$];
  int          num_errors = 0, num_checks = 0, seed = 54, k, i;
  event        rd_ev;
  always #5 clk_sys_i = ~clk_sys_i;
  debug_target_select dut_u (.clk_sys_i, .rst_n_i, .debug_link_clock_i(lck),
    .debug_link_data_i(line), .debug_link_data_o(d_o), .debug_link_data_oe_o(oe),
    .target_select_o(tsel), .flash_ctrl_rdata_i(crd), .flash_data_rdata_i(drd),
    .flash_wdata_o(wdat), .flash_ctrl_wr_o(cwr), .flash_data_wr_o(dwr),
    .flash_ctrl_rd_o(crs), .flash_data_rd_o(drs));
  debug_host_model host_u (.clk_sys_i, .dev_data_i(d_o), .dev_oe_i(oe),
    .link_clock_o(lck), .line_o(line));
  // ============================================================
  // Comparison, verdict and result monitor
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic take(input logic [11:0] obs);
    check("result", obs, exp_q.size() ? exp_q.pop_front() : 12'hfff);
  endtask
  always @(negedge clk_sys_i) begin
    if (cwr === 1'b1) take({4'h1, wdat});
    if (dwr === 1'b1) take({4'h2, wdat});
    if (crs === 1'b1) take(12'h300);
    if (drs === 1'b1) take(12'h400);
    if (tsel !== prev_tsel) take({4'h6, tsel});
    prev_tsel = tsel;
  end
  always @(rd_ev) take({4'h5, rb});
  // ============================================================
  // Frames and expected read values
  task automatic xfer(input logic [1:0] ins, input logic [7:0] w);
    host_u.frame(ins, w, rb);
    if (!ins[0]) -> rd_ev;
  endtask
  function automatic logic [7:0] rdv(input logic [7:0] s);
    case (s)
      `TSEL_DEVICE_ID: rdv = 8'h5a;
      `TSEL_REVISION_ID: rdv = 8'h01;
      `TSEL_FLASH_CTRL: rdv = crd;
      `TSEL_FLASH_DATA: rdv = drd;
      default: rdv = `UNMAPPED_READ;
    endcase
  endfunction
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    exp_q.push_back(12'h500);
    xfer(`INS_ADDR_READ, 8'h00);
    // Every select value, back-to-back writes, then a read
    for (k = 0; k < 5; k++) begin
      @(posedge clk_sys_i);
      #1 crd = 8'($random(seed));
      drd = 8'($random(seed));
      exp_q.push_back({4'h6, sels[k]});
      exp_q.push_back({4'h5, sels[k]});
      xfer(`INS_ADDR_WRITE, sels[k]);
      xfer(`INS_ADDR_READ, 8'h00);
      for (i = 0; i < 2; i++) begin
        wd = 8'($random(seed));
        if (sels[k] == 8'h02) exp_q.push_back({4'h1, wd});
        if (sels[k] == 8'hb4) exp_q.push_back({4'h2, wd});
        xfer(`INS_DATA_WRITE, wd);
      end
      if (sels[k] == 8'h02) exp_q.push_back(12'h300);
      if (sels[k] == 8'hb4) exp_q.push_back(12'h400);
      exp_q.push_back({4'h5, rdv(sels[k])});
      xfer(`INS_DATA_READ, 8'h00);
    end
    // Second reset clears the select back to device identity
    exp_q.push_back(12'h600);
    @(posedge clk_sys_i);
    #1 rst_n_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    exp_q.push_back({4'h5, 8'h5a});
    xfer(`INS_DATA_READ, 8'h00);
    for (i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge clk_sys_i);
    if (exp_q.size() != 0) num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
